// ---- include/hia_cfg.svh ----
/*
 * constants of the host interrupt aggregator: register offsets, field positions,
 * reset values and field widths.
 * assumes a 32-bit apb with byte addresses and one word per register.
 */
`ifndef HIA_CFG_SVH
`define HIA_CFG_SVH

`define HIA_ADDR_W          12
`define HIA_OFF_RX_MASK     12'h1DC
`define HIA_OFF_RX_FLAGS    12'h1D8
`define HIA_OFF_STATUS      12'h1E8
`define HIA_OFF_HOST_MASK   12'h1EC
`define HIA_OFF_RX_DELAY    12'h1F0
`define HIA_OFF_EVT_STAT    12'h1F4
`define HIA_OFF_EVT_CLR     12'h1F8
`define HIA_OFF_EVT_EN      12'h1FC

`define HIA_RESET_WORD      32'h0000_0000
`define HIA_STATUS_USED     32'h001F_19BF
`define HIA_LOW_MASK        32'h0000_FFFF

`define HIA_BIT_WAKE        20
`define HIA_BIT_QSTAT       19
`define HIA_BIT_QOVUN       18
`define HIA_BIT_PHY         17
`define HIA_BIT_RMON        16
`define HIA_BIT_TX_BAD      12
`define HIA_BIT_RX_BAD      11
`define HIA_BIT_LATE_RX     8
`define HIA_BIT_EARLY_RX    7
`define HIA_BIT_LATE_TX     5
`define HIA_BIT_EARLY_TX    4
`define HIA_BIT_WMARK       3
`define HIA_BIT_NOMEM       2
`define HIA_BIT_PAUSE       1
`define HIA_BIT_CLASS       0

`define HIA_DELAY_W         16
`define HIA_EVT_W           3

`endif

// ---- include/hia_pkg.sv ----
/*
 * types of the host interrupt aggregator.
 * assumes hia_cfg.svh for widths.
 */
`default_nettype none
`include "hia_cfg.svh"
package hia_pkg;
    typedef logic [31:0] hia_word_t;
    typedef logic [`HIA_DELAY_W-1:0] hia_delay_t;
    typedef enum logic [2:0]
    {
        HIA_DLY_IDLE = 3'h1,
        HIA_DLY_WAIT = 3'h2,
        HIA_DLY_FIRE = 3'h4
    } hia_dly_e;
endpackage : hia_pkg
`default_nettype wire

// ---- include/hia_dly_if.sv ----
/*
 * carrier between the aggregator and its receive start delay timer.
 * assumes a single clock domain.
 */
`default_nettype none
`include "hia_cfg.svh"
interface hia_dly_if;
    logic              start;
    hia_pkg::hia_delay_t delay;
    logic              fire;
    modport owner (output start, output delay, input fire);
    modport timer (input start, input delay, output fire);
endinterface : hia_dly_if
`default_nettype wire

// ---- rtl/hia_dly_timer.sv ----
/*
 * postpones the receive start notice by a programmed number of cycles.
 * assumes starts arrive as one-cycle pulses; a start during a wait is dropped.
 */
`default_nettype none
`include "hia_cfg.svh"
module hia_dly_timer
(
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // owner side
    hia_dly_if.timer    dly
);
    hia_pkg::hia_dly_e   state_q;
    hia_pkg::hia_delay_t cnt_q;

    // delay zero fires one cycle after the start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= hia_pkg::HIA_DLY_IDLE;
            cnt_q   <= '0;
        end
        else
        begin
            case (state_q)
                hia_pkg::HIA_DLY_IDLE:
                begin
                    if (dly.start)
                    begin
                        cnt_q   <= dly.delay;
                        state_q <= (dly.delay == '0) ? hia_pkg::HIA_DLY_FIRE : hia_pkg::HIA_DLY_WAIT;
                    end
                end
                hia_pkg::HIA_DLY_WAIT:
                begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == `HIA_DELAY_W'(1))
                        state_q <= hia_pkg::HIA_DLY_FIRE;
                end
                hia_pkg::HIA_DLY_FIRE:
                    state_q <= hia_pkg::HIA_DLY_IDLE;
                default:
                    state_q <= hia_pkg::HIA_DLY_IDLE;
            endcase
        end
    end

    assign dly.fire = (state_q == hia_pkg::HIA_DLY_FIRE);

    fire_after_start_a : assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == hia_pkg::HIA_DLY_IDLE && dly.start && dly.delay == '0) |=> dly.fire)
        else $error("zero delay did not fire next cycle");
endmodule : hia_dly_timer
`default_nettype wire

// ---- rtl/hia_top.sv ----
/*
 * host interrupt aggregator: status, masks, rx statistics rollover flags,
 * apb register slave and the two level interrupt outputs, host_irq and evt_irq.
 * assumes event inputs are one-cycle pulses, except the levels tx_done_req, tx_begin_req and local_pause, and summary sources are levels,
 * all synchronous to pclk.
 */
`default_nettype none
`include "hia_cfg.svh"
module hia_top
(
    // apb
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`HIA_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // summary sources, levels
    input  wire logic                   power_event_n,
    input  wire logic                   queue_state_irq_reg,
    input  wire logic                   queue_overrun_irq_reg,
    input  wire logic                   phy_irq,
    // statistics rollover pulses, one per counter
    input  wire logic [31:0]            rx_stats_rollover,
    // frame and memory events, pulses; tx_done_req, tx_begin_req and local_pause are levels
    input  wire logic                   tx_frame_err,
    input  wire logic                   rx_frame_err,
    input  wire logic                   rx_frame_queued,
    input  wire logic                   rx_frame_start,
    input  wire logic                   tx_done,
    input  wire logic                   tx_begin,
    input  wire logic                   tx_done_req,
    input  wire logic                   tx_begin_req,
    input  wire logic                   free_at_low_mark,
    input  wire logic                   mem_req_none_free,
    input  wire logic                   local_pause,
    input  wire logic                   class_event,
    // interrupts
    output logic                        host_irq,
    output logic                        evt_irq
);
    hia_pkg::hia_word_t  rx_flags_q;
    hia_pkg::hia_word_t  rx_mask_q;
    hia_pkg::hia_word_t  host_mask_q;
    logic [15:0]         low_q;
    hia_pkg::hia_delay_t rx_delay_q;
    logic                pause_q;
    logic [`HIA_EVT_W-1:0] evt_stat_q;
    logic [`HIA_EVT_W-1:0] evt_en_q;
    logic                host_irq_q;
    logic                evt_irq_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;

    hia_dly_if dly ();
    hia_dly_timer u_dly
    (
        .pclk    (pclk),
        .presetn (presetn),
        .dly     (dly)
    );
    assign dly.start = rx_frame_start;
    assign dly.delay = rx_delay_q;

    function automatic logic hit(input logic [`HIA_ADDR_W-1:0] a, input logic [`HIA_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // one wait state: request taken in the first access cycle, answer the next
    wire setup_ok = psel && penable && !pready_q;
    wire wr_acc   = setup_ok && pwrite;
    wire rd_acc   = setup_ok && !pwrite;
    wire rd_stat  = rd_acc && hit(paddr, `HIA_OFF_STATUS);
    wire rd_flags = rd_acc && hit(paddr, `HIA_OFF_RX_FLAGS);
    wire mapped   = hit(paddr, `HIA_OFF_RX_MASK) || hit(paddr, `HIA_OFF_RX_FLAGS)
                 || hit(paddr, `HIA_OFF_STATUS) || hit(paddr, `HIA_OFF_HOST_MASK)
                 || hit(paddr, `HIA_OFF_RX_DELAY) || hit(paddr, `HIA_OFF_EVT_STAT)
                 || hit(paddr, `HIA_OFF_EVT_CLR) || hit(paddr, `HIA_OFF_EVT_EN);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    endfunction : merge

    // rollover flags clear on read; a rollover in the read cycle survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_flags_q <= `HIA_RESET_WORD;
        else
            rx_flags_q <= (rd_flags ? '0 : rx_flags_q) | rx_stats_rollover;
    end

    // enabled rollovers form the statistics summary source
    wire rmon_src = |(rx_flags_q & rx_mask_q);

    // event flags of the low half
    logic [15:0] low_set;
    always_comb
    begin
        low_set = '0;
        low_set[`HIA_BIT_TX_BAD]   = tx_frame_err;
        low_set[`HIA_BIT_RX_BAD]   = rx_frame_err;
        low_set[`HIA_BIT_LATE_RX]  = rx_frame_queued;
        low_set[`HIA_BIT_EARLY_RX] = dly.fire;
        low_set[`HIA_BIT_LATE_TX]  = tx_done && tx_done_req;
        low_set[`HIA_BIT_EARLY_TX] = tx_begin && tx_begin_req;
        low_set[`HIA_BIT_WMARK]    = free_at_low_mark;
        low_set[`HIA_BIT_NOMEM]    = mem_req_none_free;
        low_set[`HIA_BIT_PAUSE]    = local_pause ^ pause_q;
        low_set[`HIA_BIT_CLASS]    = class_event;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pause_q <= 1'b0;
        else
            pause_q <= local_pause;
    end

    // clear on read, with a set in the read cycle winning
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_q <= '0;
        else
            low_q <= ((rd_stat ? 16'h0000 : low_q) | low_set) & 16'(`HIA_STATUS_USED);
    end

    // summary bits are live views of their sources, never stored
    hia_pkg::hia_word_t status;
    always_comb
    begin
        status = '0;
        status[15:0]             = low_q;
        status[`HIA_BIT_WAKE]    = !power_event_n;
        status[`HIA_BIT_QSTAT]   = queue_state_irq_reg;
        status[`HIA_BIT_QOVUN]   = queue_overrun_irq_reg;
        status[`HIA_BIT_PHY]     = phy_irq;
        status[`HIA_BIT_RMON]    = rmon_src;
    end

    // writable registers; the status register ignores writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_mask_q   <= `HIA_RESET_WORD;
            host_mask_q <= `HIA_RESET_WORD;
            rx_delay_q  <= '0;
            evt_en_q    <= '0;
        end
        else if (wr_acc)
        begin
            if (hit(paddr, `HIA_OFF_RX_MASK))
                rx_mask_q <= merge(rx_mask_q, pwdata, pstrb);
            if (hit(paddr, `HIA_OFF_HOST_MASK))
                host_mask_q <= merge(host_mask_q, pwdata, pstrb);
            if (hit(paddr, `HIA_OFF_RX_DELAY))
                rx_delay_q <= pwdata[`HIA_DELAY_W-1:0];
            if (hit(paddr, `HIA_OFF_EVT_EN))
                evt_en_q <= pwdata[`HIA_EVT_W-1:0];
        end
    end

    // block events: 0 unmapped access, 1 status read, 2 write to read-only status
    logic [`HIA_EVT_W-1:0] evt_set;
    assign evt_set = {wr_acc && hit(paddr, `HIA_OFF_STATUS), rd_stat, setup_ok && !mapped};
    wire [`HIA_EVT_W-1:0] evt_clr = (wr_acc && hit(paddr, `HIA_OFF_EVT_CLR)) ? pwdata[`HIA_EVT_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_stat_q <= '0;
        else
            evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
    end

    // registered interrupt outputs trail the status by one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_irq_q <= 1'b0;
            evt_irq_q  <= 1'b0;
        end
        else
        begin
            host_irq_q <= |(status & host_mask_q);
            evt_irq_q  <= |(evt_stat_q & evt_en_q);
        end
    end

    // apb answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup_ok;
            pslverr_q <= setup_ok && !mapped;
            prdata_q  <= '0;
            if (rd_acc)
            begin
                case (1'b1)
                    hit(paddr, `HIA_OFF_RX_MASK):   prdata_q <= rx_mask_q;
                    hit(paddr, `HIA_OFF_RX_FLAGS):  prdata_q <= rx_flags_q;
                    hit(paddr, `HIA_OFF_STATUS):    prdata_q <= status;
                    hit(paddr, `HIA_OFF_HOST_MASK): prdata_q <= host_mask_q;
                    hit(paddr, `HIA_OFF_RX_DELAY):  prdata_q <= {16'h0000, rx_delay_q};
                    hit(paddr, `HIA_OFF_EVT_STAT):  prdata_q <= {29'h0, evt_stat_q};
                    hit(paddr, `HIA_OFF_EVT_EN):    prdata_q <= {29'h0, evt_en_q};
                    default:                         prdata_q <= '0;
                endcase
            end
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign host_irq = host_irq_q;
    assign evt_irq  = evt_irq_q;

    // checks
    irq_follows_mask_a : assert property (@(posedge pclk) disable iff (!presetn)
        host_irq == $past(|(status & host_mask_q)))
        else $error("host interrupt disagrees with masked status");
    masked_no_irq_a : assert property (@(posedge pclk) disable iff (!presetn)
        (host_mask_q == '0) |=> !host_irq)
        else $error("interrupt raised with all mask bits clear");
    rmon_gated_a : assert property (@(posedge pclk) disable iff (!presetn)
        ((rx_flags_q & rx_mask_q) == '0) |-> !status[`HIA_BIT_RMON])
        else $error("masked rollover reached summary");
    wake_view_a : assert property (@(posedge pclk) disable iff (!presetn)
        !power_event_n |-> status[`HIA_BIT_WAKE])
        else $error("wake bit low while power event asserted");
    summary_keep_a : assert property (@(posedge pclk) disable iff (!presetn)
        (rd_stat && queue_state_irq_reg) |=> $past(status[`HIA_BIT_QSTAT]) && prdata[`HIA_BIT_QSTAT])
        else $error("summary bit lost on read");
    low_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        (rd_stat && low_set == '0) |=> low_q == '0)
        else $error("event flags not cleared by read");
    set_wins_a : assert property (@(posedge pclk) disable iff (!presetn)
        rx_frame_queued |=> low_q[`HIA_BIT_LATE_RX])
        else $error("queued frame event lost");
    pause_edge_a : assert property (@(posedge pclk) disable iff (!presetn)
        (local_pause != $past(local_pause)) |=> low_q[`HIA_BIT_PAUSE])
        else $error("pause change not flagged");
    reserved_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
        (status & ~`HIA_STATUS_USED) == '0)
        else $error("reserved status bit set");
    tx_sel_a : assert property (@(posedge pclk) disable iff (!presetn)
        (!low_q[`HIA_BIT_LATE_TX] && tx_done && !tx_done_req) |=> !low_q[`HIA_BIT_LATE_TX])
        else $error("unrequested completion flagged");

    cov_irq_c     : cover property (@(posedge pclk) disable iff (!presetn) $rose(host_irq));
    cov_rd_clr_c  : cover property (@(posedge pclk) disable iff (!presetn) rd_stat && low_q != '0);
    cov_early_c   : cover property (@(posedge pclk) disable iff (!presetn) dly.fire);
    cov_unmap_c   : cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : hia_top
`default_nettype wire

// ---- bench/hia_evt_model.sv ----
/*
 * event source model for the aggregator: level sources and one-cycle pulses.
 * assumes the bench calls its tasks; outputs change by nba after a rising edge.
 */
`default_nettype none
module hia_evt_model
(
    // clock
    input  wire logic pclk,
    // levels: power_event_n, qstat, qovun, phy, pause, tx_done_req, tx_begin_req
    output var  logic [6:0]  lv,
    // pulses: tx err, rx err, queued, rx start, tx done, tx begin, low mark, no mem, class
    output var  logic [8:0]  pulses,
    output var  logic [31:0] rollover
);
    timeunit 1ns;
    timeprecision 1ps;

    // power event idles high: it is active low
    initial
    begin
        lv       = 7'h01;
        pulses   = 9'h000;
        rollover = 32'h0000_0000;
    end

    task automatic set(input logic [6:0] l);
        @(posedge pclk);
        lv <= l;
    endtask : set

    // pulses last exactly one cycle, as the design expects
    task automatic pulse(input logic [8:0] p, input logic [31:0] r);
        @(posedge pclk);
        pulses   <= p;
        rollover <= r;
        @(posedge pclk);
        pulses   <= 9'h000;
        rollover <= 32'h0000_0000;
    endtask : pulse
endmodule : hia_evt_model
`default_nettype wire

// ---- bench/testbench.sv ----
/*
 * self-checking bench for hia_top: apb tasks and scenario calls.
 * assumes hia_evt_model as event source and hia_cfg.svh for offsets.
 */
`default_nettype none
`include "hia_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, host_irq, evt_irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rollover, rd;
    logic [3:0]  pstrb;
    logic [8:0]  pulses;
    logic [6:0]  lv;
    int          miscompares;
    int          checks_done;
    int          ebit [9] = '{`HIA_BIT_TX_BAD, `HIA_BIT_RX_BAD, `HIA_BIT_LATE_RX, `HIA_BIT_EARLY_RX,
                              `HIA_BIT_LATE_TX, `HIA_BIT_EARLY_TX, `HIA_BIT_WMARK, `HIA_BIT_NOMEM, `HIA_BIT_CLASS};

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    hia_evt_model src (.pclk(pclk), .lv(lv), .pulses(pulses), .rollover(rollover));

    hia_top dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_event_n(lv[0]), .queue_state_irq_reg(lv[1]),
        .queue_overrun_irq_reg(lv[2]), .phy_irq(lv[3]), .rx_stats_rollover(rollover),
        .tx_frame_err(pulses[0]), .rx_frame_err(pulses[1]), .rx_frame_queued(pulses[2]),
        .rx_frame_start(pulses[3]), .tx_done(pulses[4]), .tx_begin(pulses[5]),
        .tx_done_req(lv[5]), .tx_begin_req(lv[6]), .free_at_low_mark(pulses[6]),
        .mem_req_none_free(pulses[7]), .local_pause(lv[4]), .class_event(pulses[8]),
        .host_irq(host_irq), .evt_irq(evt_irq)
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request held until pready is sampled high; data taken at that same edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            $display("Error pready expected 1 seen %b", pready);
            end_sim;
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rd_chk

    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_sim;
    end

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'hF;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`HIA_OFF_RX_MASK, 32'h0000_0000, "rx mask reset");
        rd_chk(`HIA_OFF_HOST_MASK, 32'h0000_0000, "host mask reset");
        wr(`HIA_OFF_STATUS, 32'hFFFF_FFFF);
        rd_chk(`HIA_OFF_STATUS, 32'h0000_0000, "status written");
        rd_chk(`HIA_OFF_EVT_STAT, 32'h0000_0006, "evt read and write");
        src.set(7'h61);
        for (int i = 0; i < 9; i++)
        begin
            if (i == 3)
                continue;
            src.pulse(9'(1 << i), 32'h0000_0000);
            rd_chk(`HIA_OFF_STATUS, 32'(1 << ebit[i]), "event bit");
            rd_chk(`HIA_OFF_STATUS, 32'h0000_0000, "event cleared");
        end
        // without the control word request the tx notices stay quiet
        src.set(7'h01);
        src.pulse(9'h030, 32'h0000_0000);
        rd_chk(`HIA_OFF_STATUS, 32'h0000_0000, "unrequested tx");
        src.set(7'h11);
        rd_chk(`HIA_OFF_STATUS, 32'h0000_0002, "pause on");
        src.set(7'h01);
        rd_chk(`HIA_OFF_STATUS, 32'h0000_0002, "pause off");
        wr(`HIA_OFF_RX_DELAY, 32'd20);
        src.pulse(9'h008, 32'h0000_0000);
        rd_chk(`HIA_OFF_STATUS, 32'h0000_0000, "early rx held");
        repeat (25) @(posedge pclk);
        rd_chk(`HIA_OFF_STATUS, 32'h0000_0080, "early rx");
        for (int j = 0; j < 4; j++)
        begin
            src.set(j == 0 ? 7'h00 : 7'h01 | 7'(1 << j));
            rd_chk(`HIA_OFF_STATUS, 32'(1 << (`HIA_BIT_WAKE - j)), "summary set");
            rd_chk(`HIA_OFF_STATUS, 32'(1 << (`HIA_BIT_WAKE - j)), "summary kept");
            src.set(7'h01);
            rd_chk(`HIA_OFF_STATUS, 32'h0000_0000, "summary gone");
        end
        wr(`HIA_OFF_RX_MASK, 32'h0000_0008);
        src.pulse(9'h000, 32'h0000_0020);
        rd_chk(`HIA_OFF_STATUS, 32'h0000_0000, "masked rollover");
        src.pulse(9'h000, 32'h0000_0008);
        rd_chk(`HIA_OFF_STATUS, 32'h0001_0000, "rollover summary");
        rd_chk(`HIA_OFF_RX_FLAGS, 32'h0000_0028, "rollover flags");
        rd_chk(`HIA_OFF_RX_FLAGS, 32'h0000_0000, "flags cleared");
        rd_chk(`HIA_OFF_STATUS, 32'h0000_0000, "summary follows");
        pstrb <= 4'h1;
        wr(`HIA_OFF_HOST_MASK, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        rd_chk(`HIA_OFF_HOST_MASK, 32'h0000_00FF, "mask bytes");
        src.pulse(9'h001, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        chk("irq masked", 32'h0, 32'(host_irq));
        wr(`HIA_OFF_HOST_MASK, 32'h0000_1000);
        repeat (3) @(posedge pclk);
        chk("irq raised", 32'h1, 32'(host_irq));
        rd_chk(`HIA_OFF_STATUS, 32'h0000_1000, "masked bit kept");
        repeat (3) @(posedge pclk);
        chk("irq dropped", 32'h0, 32'(host_irq));
        // block events: unmapped access raises, enable masks, clear drops
        wr(`HIA_OFF_EVT_CLR, 32'h0000_0007);
        wr(`HIA_OFF_EVT_EN, 32'h0000_0001);
        xfer(1'b0, 12'h100, 32'h0000_0000);
        chk("unmapped error", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        repeat (3) @(posedge pclk);
        chk("evt irq", 32'h1, 32'(evt_irq));
        rd_chk(`HIA_OFF_EVT_STAT, 32'h0000_0001, "evt status");
        wr(`HIA_OFF_EVT_CLR, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        chk("evt irq cleared", 32'h0, 32'(evt_irq));
        wr(`HIA_OFF_EVT_EN, 32'h0000_0000);
        xfer(1'b0, 12'h100, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        chk("evt irq disabled", 32'h0, 32'(evt_irq));
        end_sim;
    end
endmodule : testbench
`default_nettype wire
